// *** logic/ctsp_tx_packer.sv ***
// Purpose: periodic transmit frame builder, four signals per channel
// Assumes: config and source values come from logic on ref_clk_i
// Notes: one frame offered at a time on a valid/ready port
`timescale 1ns/1ps
`default_nettype none
`include "ctsp_cfg.svh"
module ctsp_tx_packer
	import ctsp_pkg::*;
#(
	parameter int NCH = `CTSP_NUM_CHAN,
	parameter int NCAT = `CTSP_NUM_CAT,
	parameter int NINST = `CTSP_NUM_INST,
	parameter int TICK_CYC = `CTSP_MS_NS / `CTSP_CLK_PERIOD_NS
)(
	input wire logic ref_clk_i,                              // 10 MHz clock
	input wire logic nrst_i,                                 // sync reset, low
	input wire ctsp_chan_cfg_t chan_cfg_i [NCH],             // channel setup
	input wire logic signed [31:0] src_val_i [NCAT][NINST],  // source values
	input wire logic [7:0] src_addr_i,                       // own node address
	output ctsp_frame_t frame_o,                             // frame to send
	output logic frame_valid_o,                              // frame offered
	input wire logic frame_ready_i,                          // controller takes it
	output logic [NCH-1:0] pend_o,                           // frames waiting
	output logic busy_o                                      // building/offering
);

	localparam int NSLOT = `CTSP_NUM_SLOT;
	localparam int IW = (NCH > 1) ? $clog2(NCH) : 1;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOAD = 2'b01,
		ST_SEND = 2'b11
	} ctsp_state_t;

	function automatic logic [3:0] inst_count(input ctsp_src_cat_t cat);
		unique case (cat)
			CTSP_SRC_NONE: inst_count = `CTSP_INST_CNT_0;
			CTSP_SRC_CONST: inst_count = `CTSP_INST_CNT_1;
			CTSP_SRC_OUTPUT: inst_count = `CTSP_INST_CNT_2;
			CTSP_SRC_LOOKUP: inst_count = `CTSP_INST_CNT_3;
			CTSP_SRC_LOGIC: inst_count = `CTSP_INST_CNT_4;
			CTSP_SRC_MATH: inst_count = `CTSP_INST_CNT_5;
			CTSP_SRC_CAN_RX: inst_count = `CTSP_INST_CNT_6;
			CTSP_SRC_DIAG: inst_count = `CTSP_INST_CNT_7;
		endcase
	endfunction

	function automatic logic [IW-1:0] lowest_set(input logic [NCH-1:0] v);
		lowest_set = '0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (v[i]) begin
				lowest_set = IW'(i);
			end
		end
	endfunction

	// millisecond prescaler shared by all channel timers
	// one shared tick keeps sharers aligned to their governor's count
	logic [$clog2(TICK_CYC+1)-1:0] pre_cnt;
	logic ms_tick;

	assign ms_tick = (pre_cnt == ($clog2(TICK_CYC+1))'(TICK_CYC - 1));

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i || ms_tick) begin
			pre_cnt <= '0;
		end else begin
			pre_cnt <= pre_cnt + 1'b1;
		end
	end

	// governor: lowest enabled channel holding the same group number
	logic [IW-1:0] gov_idx [NCH];
	logic [NCH-1:0] is_gov;
	logic [NCH-1:0] run;
	logic [NCH-1:0] fire;
	logic [NCH-1:0] due;
	logic [15:0] ms_cnt [NCH];
	logic [63:0] chan_data [NCH];

	genvar c, s;
	generate
		for (c = 0; c < NCH; c++) begin : g_chan
			logic [NCH-1:0] same_grp;
			logic [63:0] slot_field [NSLOT];
			logic [63:0] slot_mask [NSLOT];
			logic signed [31:0] slot_val [NSLOT];
			logic [63:0] chan_word;

			// only lower or equal indices count, so each channel finds its governor
			for (genvar j = 0; j < NCH; j++) begin : g_cmp
				assign same_grp[j] = (j <= c) && chan_cfg_i[j].en
					&& (chan_cfg_i[j].pgn == chan_cfg_i[c].pgn);
			end

			assign gov_idx[c] = lowest_set(same_grp);
			assign is_gov[c] = chan_cfg_i[c].en && (gov_idx[c] == IW'(c));
			// a zero period stops the timer, so sharers never fire either
			assign run[c] = is_gov[c] && (chan_cfg_i[c].period_ms != 16'h0);
			assign fire[c] = run[c] && ms_tick
				&& (ms_cnt[c] == chan_cfg_i[c].period_ms - 16'h1);
			assign due[c] = chan_cfg_i[c].en && fire[gov_idx[c]];

			// sharers and stopped channels hold zero, so a new governor starts fresh
			always_ff @(posedge ref_clk_i) begin
				if (!nrst_i || !run[c] || fire[c]) begin
					ms_cnt[c] <= 16'h0;
				end else if (ms_tick) begin
					ms_cnt[c] <= ms_cnt[c] + 16'h1;
				end
			end

			for (s = 0; s < NSLOT; s++) begin : g_slot
				ctsp_slot_cfg_t sc;
				logic inst_ok;

				assign sc = chan_cfg_i[c].slot[s];
				// out-of-range instance reads as zero rather than aliasing
				assign inst_ok = ({1'b0, sc.src_inst} < inst_count(sc.src_cat));
				assign slot_val[s] = inst_ok ? src_val_i[sc.src_cat][sc.src_inst] : 32'sh0;

				ctsp_signal_encoder u_enc (
					.cfg_i(sc),
					.val_i(slot_val[s]),
					.field_o(slot_field[s]),
					.mask_o(slot_mask[s])
				);
			end

			// higher slot wins where placements overlap
			always_comb begin
				logic [63:0] acc;
				acc = 64'h0;
				for (int k = 0; k < NSLOT; k++) begin
					acc = (acc & ~slot_mask[k]) | slot_field[k];
				end
				chan_word = acc;
			end
			// one driver per element keeps the array free of shared writers
			assign chan_data[c] = chan_word;
		end
	endgenerate

	// frame header of the channel about to be loaded
	ctsp_state_t state;
	ctsp_state_t next_state;
	logic [NCH-1:0] pend;
	logic [NCH-1:0] pend_clr;
	logic [IW-1:0] sel;
	logic [IW-1:0] next_sel;
	ctsp_chan_cfg_t sel_cfg;
	logic [7:0] sel_pf;
	logic [7:0] sel_ps;
	logic [3:0] sel_dlc;
	ctsp_frame_t next_frame;

	assign sel_cfg = chan_cfg_i[sel];
	assign sel_pf = sel_cfg.pgn[15:8];
	// destination-specific format when the format byte is below the PDU2 range
	assign sel_ps = (sel_pf < `CTSP_PDU2_PF) ? sel_cfg.dest : sel_cfg.pgn[7:0];
	// length outside 1..8 is sent as a full frame
	assign sel_dlc = ((sel_cfg.len == 4'h0) || (sel_cfg.len > `CTSP_MAX_DLC)) ?
		`CTSP_MAX_DLC : sel_cfg.len;
	// one assignment keeps the frame a single driver
	assign next_frame = {
		{sel_cfg.prio, 2'b00, sel_pf, sel_ps, src_addr_i},
		sel_dlc,
		chan_data[sel]
	};

	// sel is frozen from LOAD to SEND so header and data come from one channel
	assign next_sel = (state == ST_IDLE) ? lowest_set(pend) : sel;
	assign pend_clr = (state == ST_LOAD) ? (NCH'(1) << sel) : '0;

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (|pend) begin
					next_state = ST_LOAD;
				end
			end
			ST_LOAD: next_state = ST_SEND;
			ST_SEND: begin
				if (frame_ready_i) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			state <= ST_IDLE;
			sel <= '0;
			pend <= '0;
		end else begin
			state <= next_state;
			sel <= next_sel;
			// a new due event wins over the clear of the same channel
			pend <= (pend & ~pend_clr) | due;
		end
	end

	// data is captured at load, so it reflects sources then, not at fire
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			frame_o <= '0;
		end else if (state == ST_LOAD) begin
			frame_o <= next_frame;
		end
	end

	// handshake outputs come straight off the state register
	assign frame_valid_o = (state == ST_SEND);
	assign busy_o = (state != ST_IDLE);
	assign pend_o = pend;

endmodule
`default_nettype wire

// *** shared/ctsp_cfg.svh ***
// Purpose: constants for the transmit signal packer
// Assumes: 10 MHz reference clock, little-endian byte order in the data field
// Notes on behaviour
// - size code 0 unused, 1=1b, 2=2b, 3=4b, 4=8b, 5=16b, 6=32b
// - signal LSB lands at byte position 0..7 of the data field
// - bit position 0..7 used only for sub-byte sizes, ignored otherwise
// - each value multiplied by its signed per-signal resolution before packing
// - per-signal signed offset added while encoding
// - each slot selects a source category from an enumerated list
// - each slot selects an instance; allowed range depends on category
// - shared group number: lowest-indexed enabled channel's period governs scheduling
// - zero period suppresses sending, even if higher sharing channels are nonzero
`ifndef CTSP_CFG_SVH
`define CTSP_CFG_SVH

`define CTSP_CLK_PERIOD_NS 100
`define CTSP_MS_NS 1000000
`define CTSP_NUM_CHAN 4
`define CTSP_NUM_SLOT 4
`define CTSP_NUM_CAT 8
`define CTSP_NUM_INST 8
`define CTSP_RES_FRAC 8
`define CTSP_PDU2_PF 8'hf0
`define CTSP_MAX_DLC 4'h8
// power-on values the configuration owner is expected to present
`define CTSP_DEF_PERIOD_MS 16'h03e8
`define CTSP_DEF_PRIO 3'h6
`define CTSP_DEF_DEST 8'hfe
// size codes
`define CTSP_SZ_NONE 3'h0
`define CTSP_SZ_1B 3'h1
`define CTSP_SZ_2B 3'h2
`define CTSP_SZ_4B 3'h3
`define CTSP_SZ_8B 3'h4
`define CTSP_SZ_16B 3'h5
`define CTSP_SZ_32B 3'h6
// instances available per source category
`define CTSP_INST_CNT_0 4'h0
`define CTSP_INST_CNT_1 4'h8
`define CTSP_INST_CNT_2 4'h4
`define CTSP_INST_CNT_3 4'h6
`define CTSP_INST_CNT_4 4'h3
`define CTSP_INST_CNT_5 4'h4
`define CTSP_INST_CNT_6 4'h8
`define CTSP_INST_CNT_7 4'h3

`endif

// *** shared/ctsp_pkg.sv ***
// Purpose: types for the transmit signal packer
// Assumes: ctsp_cfg.svh constants
// Notes: config travels as packed structs
`default_nettype none
package ctsp_pkg;

	typedef enum logic [1:0] {
		CTSP_SIG_UNDEF = 2'h0,
		CTSP_SIG_DIGITAL = 2'h1,
		CTSP_SIG_CONT = 2'h2
	} ctsp_sig_type_t;

	typedef enum logic [2:0] {
		CTSP_SRC_NONE = 3'h0,
		CTSP_SRC_CONST = 3'h1,
		CTSP_SRC_OUTPUT = 3'h2,
		CTSP_SRC_LOOKUP = 3'h3,
		CTSP_SRC_LOGIC = 3'h4,
		CTSP_SRC_MATH = 3'h5,
		CTSP_SRC_CAN_RX = 3'h6,
		CTSP_SRC_DIAG = 3'h7
	} ctsp_src_cat_t;

	typedef struct packed {
		ctsp_sig_type_t sig_type;
		ctsp_src_cat_t src_cat;
		logic [2:0] src_inst;
		logic [2:0] size;
		logic [2:0] byte_pos;
		logic [2:0] bit_pos;
		logic signed [31:0] res;
		logic signed [31:0] off;
	} ctsp_slot_cfg_t;

	typedef struct packed {
		logic en;
		logic [15:0] pgn;
		logic [15:0] period_ms;
		logic [7:0] dest;
		logic [3:0] len;
		logic [2:0] prio;
		ctsp_slot_cfg_t [3:0] slot;
	} ctsp_chan_cfg_t;

	typedef struct packed {
		logic [28:0] id;
		logic [3:0] dlc;
		logic [63:0] data;
	} ctsp_frame_t;

endpackage
`default_nettype wire

// *** logic/ctsp_signal_encoder.sv ***
// Purpose: scale one signal value and place it in a 64-bit data field
// Assumes: resolution is fixed point with CTSP_RES_FRAC fraction bits
// Notes: purely combinational; bits pushed past bit 63 are lost
`timescale 1ns/1ps
`default_nettype none
`include "ctsp_cfg.svh"
module ctsp_signal_encoder
	import ctsp_pkg::*;
(
	input wire ctsp_slot_cfg_t cfg_i,      // slot configuration
	input wire logic signed [31:0] val_i,  // selected source value
	output logic [63:0] field_o,           // value at its place
	output logic [63:0] mask_o             // bits owned by this slot
);

	function automatic logic [5:0] size_width(input logic [2:0] code);
		case (code)
			`CTSP_SZ_1B: size_width = 6'd1;
			`CTSP_SZ_2B: size_width = 6'd2;
			`CTSP_SZ_4B: size_width = 6'd4;
			`CTSP_SZ_8B: size_width = 6'd8;
			`CTSP_SZ_16B: size_width = 6'd16;
			`CTSP_SZ_32B: size_width = 6'd32;
			default: size_width = 6'd0;
		endcase
	endfunction

	logic signed [63:0] product;
	logic signed [63:0] scaled;
	logic [31:0] raw;
	logic [5:0] width;
	logic sub_byte;
	logic [5:0] pos;
	logic [63:0] width_mask;
	logic active;

	assign product = 64'(val_i) * 64'(cfg_i.res);
	assign scaled = product >>> `CTSP_RES_FRAC;
	assign raw = scaled[31:0] + cfg_i.off;
	assign width = size_width(cfg_i.size);
	assign sub_byte = (cfg_i.size == `CTSP_SZ_1B) || (cfg_i.size == `CTSP_SZ_2B)
		|| (cfg_i.size == `CTSP_SZ_4B);
	// bit index only matters below one byte
	assign pos = sub_byte ? {cfg_i.byte_pos, cfg_i.bit_pos} : {cfg_i.byte_pos, 3'h0};
	assign width_mask = (64'h1 << width) - 64'h1;
	// undefined type or unused size leaves the field untouched
	assign active = (cfg_i.sig_type != CTSP_SIG_UNDEF) && (width != 6'd0);
	assign mask_o = active ? (width_mask << pos) : 64'h0;
	assign field_o = active ? (({32'h0, raw} & width_mask) << pos) : 64'h0;

endmodule
`default_nettype wire

// *** tb/ctsp_tx_packer_chk.sv ***
// Purpose: checker on the packer's frame port and pending flags
// Assumes: ports of the top module only
// Notes: bound in below
`timescale 1ns/1ps
`default_nettype none
module ctsp_tx_packer_chk
	import ctsp_pkg::*;
#(
	parameter int NCH = 4
)(
	input wire logic ref_clk_i,         // clock
	input wire logic nrst_i,            // sync reset, low
	input wire ctsp_frame_t frame_o,    // offered frame
	input wire logic frame_valid_o,     // frame offered
	input wire logic frame_ready_i,     // frame taken
	input wire logic [NCH-1:0] pend_o,  // pending flags
	input wire logic busy_o             // busy
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!nrst_i);
	sequence s_load;
		busy_o && !frame_valid_o ##1 frame_valid_o;
	endsequence
	chk_offer_holds: assert property (frame_valid_o && !frame_ready_i |=>
		frame_valid_o && $stable(frame_o)) else $error("offer dropped or changed");
	chk_accept_gap: assert property (frame_valid_o && frame_ready_i |=>
		!busy_o && !frame_valid_o ##1 !frame_valid_o) else $error("no idle after accept");
	chk_valid_busy: assert property (!busy_o |=> !frame_valid_o) else $error("valid straight after idle");
	chk_pend_load: assert property (pend_o != '0 && !busy_o |=> s_load)
		else $error("pending frame not loaded");
	chk_pend_clear: assert property (|($past(pend_o) & ~pend_o) |->
		frame_valid_o && !$past(frame_valid_o)) else $error("pending cleared without load");
	chk_dlc_range: assert property (frame_valid_o |-> frame_o.dlc inside {[4'h1:4'h8]})
		else $error("length out of range");
	chk_id_dp_zero: assert property (frame_valid_o |-> frame_o.id[25:24] == 2'h0)
		else $error("page bits set");
	chk_send_order: assert property ($rose(frame_valid_o) |-> $past(busy_o) && !$past(busy_o, 2))
		else $error("send without load step");
endmodule
bind ctsp_tx_packer ctsp_tx_packer_chk #(.NCH(NCH)) i_chk (.ref_clk_i, .nrst_i, .frame_o,
	.frame_valid_o, .frame_ready_i, .pend_o, .busy_o);
`default_nettype wire

// *** tb/ctsp_can_sink.sv ***
// Purpose: controller stand-in that takes offered frames
// Assumes: ready can be held off a set number of cycles
// Notes: counts taken frames per priority
`timescale 1ns/1ps
`default_nettype none
module ctsp_can_sink
	import ctsp_pkg::*;
(
	input wire logic ref_clk_i,       // clock
	input wire logic nrst_i,          // sync reset, low
	input wire ctsp_frame_t frame_i,  // offered frame
	input wire logic valid_i,         // frame offered
	input wire logic [3:0] stall_i,   // hold-off cycles
	output logic ready_o,             // frame taken
	output var ctsp_frame_t last_o,   // last taken frame
	output var int cnt_o [8]          // taken per priority
);
	logic [3:0] held;
	assign ready_o = valid_i && held >= stall_i;
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			held <= 4'h0;
			foreach (cnt_o[i]) cnt_o[i] <= 0;
		end else if (ready_o) begin
			held <= 4'h0;
			last_o <= frame_i;
			cnt_o[frame_i.id[28:26]] <= cnt_o[frame_i.id[28:26]] + 1;
		end else if (valid_i) begin
			held <= held + 4'h1;
		end
	end
endmodule
`default_nettype wire

// *** tb/ctsp_tx_packer_bench.sv ***
// Purpose: directed bench for the transmit packer
// Assumes: one ms shortened to 4 cycles
// Notes: a frame is judged two takes after its setup
`timescale 1ns/1ps
`default_nettype none
module ctsp_tx_packer_bench
	import ctsp_pkg::*;
;
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	ctsp_chan_cfg_t cfg [4];
	logic signed [31:0] src [8][8];
	ctsp_frame_t frame, last;
	logic valid, ready, busy;
	logic [3:0] pend, stall;
	int cnt [8];
	int n_errors = 0;
	int compares = 0;
	initial forever #50 ref_clk_i = ~ref_clk_i;
	ctsp_tx_packer #(.TICK_CYC(4)) i_ctsp_tx_packer (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.chan_cfg_i(cfg), .src_val_i(src), .src_addr_i(8'h42), .frame_o(frame),
		.frame_valid_o(valid), .frame_ready_i(ready), .pend_o(pend), .busy_o(busy));
	ctsp_can_sink i_ctsp_can_sink (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .frame_i(frame),
		.valid_i(valid), .stall_i(stall), .ready_o(ready), .last_o(last), .cnt_o(cnt));
	task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	task automatic put(int ch, ctsp_chan_cfg_t c);
		@(posedge ref_clk_i);
		cfg[ch] <= c;
	endtask
	function automatic int tot();
		tot = 0;
		foreach (cnt[i]) tot += cnt[i];
	endfunction
	task automatic quiet();
		for (int i = 0; i < 4; i++) put(i, '0);
		cyc(20);
	endtask
	// second take: the first may have been loaded from the old setup
	task automatic take(output ctsp_frame_t f);
		int n0;
		n0 = tot();
		for (int i = 0; i < 300 && tot() < n0 + 2; i++) cyc(1);
		f = last;
		if (tot() < n0 + 2) begin
			n_errors++;
			summarize();
		end
	endtask
	function automatic ctsp_chan_cfg_t chan(logic [15:0] pgn, per, logic [2:0] prio);
		chan = '0;
		chan.en = 1'b1;
		chan.pgn = pgn;
		chan.period_ms = per;
		chan.prio = prio;
		chan.len = 4'h8;
		chan.dest = 8'h21;
	endfunction
	function automatic ctsp_slot_cfg_t slot(ctsp_src_cat_t cat, logic [2:0] inst, sz, by, bi,
		logic signed [31:0] res, off);
		slot = '{CTSP_SIG_CONT, cat, inst, sz, by, bi, res, off};
	endfunction
	initial begin
		ctsp_chan_cfg_t c;
		ctsp_frame_t f;
		int c0, c1, n0;
		int wd [8];
		wd = '{0, 1, 2, 4, 8, 16, 32, 0};
		stall = 4'h0;
		foreach (cfg[i]) cfg[i] = '0;
		foreach (src[i, j]) src[i][j] = 32'sh55;
		src[1][2] = 32'sd100;
		src[2][0] = 32'sd1;
		src[6][7] = -32'sd1;
		src[3][5] = 32'sh11;
		src[5][3] = 32'sh22;
		cyc(5);
		@(posedge ref_clk_i);
		nrst_i <= 1'b1;
		for (int k = 0; k < 8; k++) begin
			c = chan(16'hef00, 16'h1, 3'h6);
			c.slot[0] = slot(CTSP_SRC_CAN_RX, 3'h7, k[2:0], 3'h0, 3'h3, 32'sh100, 32'sh0);
			put(0, c);
			take(f);
			check("size data", f.data, ((64'h1 << wd[k]) - 64'h1) << ((k inside {[1:3]}) ? 3 : 0));
			check("pdu1 id", f.id, {3'h6, 2'h0, 16'hef21, 8'h42});
		end
		stall <= 4'h3;
		c = chan(16'hff10, 16'h1, 3'h3);
		c.len = 4'h5;
		c.slot[0] = slot(CTSP_SRC_CONST, 3'h2, 3'h5, 3'h2, 3'h6, -32'sh200, 32'sh5);
		c.slot[1] = slot(CTSP_SRC_OUTPUT, 3'h0, 3'h1, 3'h7, 3'h5, 32'sh100, 32'sh0);
		c.slot[1].sig_type = CTSP_SIG_DIGITAL;
		c.slot[2] = slot(CTSP_SRC_DIAG, 3'h5, 3'h4, 3'h4, 3'h0, 32'sh100, 32'sh7);
		c.slot[3] = slot(CTSP_SRC_CONST, 3'h2, 3'h4, 3'h0, 3'h0, 32'sh100, 32'sh0);
		c.slot[3].sig_type = CTSP_SIG_UNDEF;
		put(0, c);
		take(f);
		check("packed data", f.data, 64'h2000_0007_ff3d_0000);
		check("pdu2 id", f.id, {3'h3, 2'h0, 16'hff10, 8'h42});
		check("length", f.dlc, 4'h5);
		c = chan(16'hf0ab, 16'h1, 3'h7);
		c.len = 4'h0;
		c.slot[0] = slot(CTSP_SRC_LOOKUP, 3'h5, 3'h4, 3'h0, 3'h0, 32'sh100, 32'sh0);
		c.slot[1] = slot(CTSP_SRC_MATH, 3'h3, 3'h4, 3'h1, 3'h0, 32'sh100, 32'sh0);
		c.slot[2] = slot(CTSP_SRC_LOGIC, 3'h3, 3'h4, 3'h2, 3'h0, 32'sh100, 32'sh1);
		c.slot[3] = slot(CTSP_SRC_NONE, 3'h0, 3'h4, 3'h3, 3'h0, 32'sh100, 32'sh2);
		put(0, c);
		take(f);
		check("range data", f.data, 64'h0000_0000_0201_2211);
		check("pdu2 edge id", f.id, {3'h7, 2'h0, 16'hf0ab, 8'h42});
		check("length clamp", f.dlc, 4'h8);
		quiet();
		stall <= 4'h0;
		put(0, chan(16'h1200, 16'h6, 3'h0));
		put(1, chan(16'h1200, 16'h1, 3'h1));
		c0 = cnt[0];
		c1 = cnt[1];
		for (int i = 0; i < 400 && cnt[0] < c0 + 3; i++) cyc(1);
		if (cnt[0] < c0 + 3) begin
			n_errors++;
			summarize();
		end
		cyc(12);
		check("governor frames", cnt[0] - c0, 3);
		check("sharer frames", cnt[1] - c1, 3);
		quiet();
		n0 = tot();
		put(0, chan(16'h3400, 16'h0, 3'h0));
		put(1, chan(16'h3400, 16'h1, 3'h1));
		c = chan(16'h5600, 16'h1, 3'h2);
		c.en = 1'b0;
		put(2, c);
		cyc(200);
		check("suppressed frames", tot() - n0, 0);
		check("pending flags", pend, 4'h0);
		put(3, chan(16'h7800, 16'h1, 3'h2));
		cyc(10);
		@(posedge ref_clk_i);
		nrst_i <= 1'b0;
		cyc(5);
		check("reset state", {busy, valid, pend}, 6'h0);
		check("reset frame", {frame.id, frame.dlc}, 33'h0);
		@(posedge ref_clk_i);
		nrst_i <= 1'b1;
		take(f);
		check("after reset id", f.id, {3'h2, 2'h0, 16'h7821, 8'h42});
		summarize();
	end
endmodule
`default_nettype wire
